// ---- sfwec_cfg.svh ----
`ifndef SFWEC_CFG_SVH
`define SFWEC_CFG_SVH

// Opcodes
`define SFWEC_OP_SET_WRITE_LATCH 8'h06
`define SFWEC_OP_CLEAR_WRITE_LATCH 8'h04
`define SFWEC_OP_STATUS_READ 8'h05
`define SFWEC_OP_STATUS_WRITE 8'h01
`define SFWEC_OP_WRITE_LO 8'h02
`define SFWEC_OP_WRITE_HI 8'h0a
`define SFWEC_OP_READ_LO 8'h03
`define SFWEC_OP_READ_HI 8'h0b

// Opcode bit that carries address bit 8
`define SFWEC_OP_ADDR_MSB_BIT 3

// Status byte fields
`define SFWEC_SR_LATCH_BIT 1
`define SFWEC_SR_GUARD_LOW_BIT 2
`define SFWEC_SR_GUARD_HIGH_BIT 3
`define SFWEC_SR_LATCH_RESET 1'h0
`define SFWEC_SR_GUARD_RESET 2'h0

// Geometry and framing
`define SFWEC_ADDR_BITS 9
`define SFWEC_MEM_DEPTH 512
`define SFWEC_LAST_BIT 3'h7
`define SFWEC_SYNC_BITS 3

`endif

// ---- sfwec_pkg.sv ----
package sfwec_pkg;
	typedef enum logic [1:0] {
		SFWEC_IDLE = 2'b00,
		SFWEC_OPCODE = 2'b01,
		SFWEC_ADDR = 2'b11,
		SFWEC_DATA = 2'b10
	} sfwec_state_t;
endpackage

// ---- sfwec_sync.sv ----
`timescale 1ns/100ps
`include "sfwec_cfg.svh"
module sfwec_sync (
	input wire logic clock, // System clock
	input wire logic rst_b, // Async reset, active low
	input wire logic [`SFWEC_SYNC_BITS-1:0] async_in, // Pin levels
	output logic [`SFWEC_SYNC_BITS-1:0] sync_out // Two-stage synchronised levels
);
	logic [`SFWEC_SYNC_BITS-1:0] first_stage;
	genvar i;
	generate
		for (i = 0; i < `SFWEC_SYNC_BITS; i = i + 1) begin : g_bit
			always_ff @(posedge clock or negedge rst_b) begin
				if (!rst_b) begin
					first_stage[i] <= 1'b0;
					sync_out[i] <= 1'b0;
				end else begin
					first_stage[i] <= async_in[i];
					sync_out[i] <= first_stage[i];
				end
			end
		end
	endgenerate
endmodule

// ---- sfwec_mem.sv ----
`timescale 1ns/100ps
`include "sfwec_cfg.svh"
module sfwec_mem (
	input wire logic clock, // System clock
	input wire logic rst_b, // Async reset, active low
	input wire logic we, // Write strobe
	input wire logic [`SFWEC_ADDR_BITS-1:0] addr, // Byte address
	input wire logic [7:0] wdata, // Write byte
	output logic [7:0] rdata // Registered read byte
);
	logic [7:0] cells [0:`SFWEC_MEM_DEPTH-1];

	// Array has no reset; contents are nonvolatile in spirit
	always_ff @(posedge clock) begin
		if (we) begin
			cells[addr] <= wdata;
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			rdata <= 8'h00;
		end else begin
			rdata <= cells[addr];
		end
	end
endmodule

// ---- sfwec_top.sv ----
`timescale 1ns/100ps
`include "sfwec_cfg.svh"
module sfwec_top (
	input wire logic clock, // 200 MHz system clock
	input wire logic rst_b, // Async reset, active low
	input wire logic spi_clk, // Serial clock pin, mode 0 or 3
	input wire logic spi_cs_b, // Chip select pin, active low
	input wire logic spi_mosi, // Serial data in
	output logic spi_miso, // Serial data out
	output logic spi_miso_oe_b, // Data out enable, low while driving
	output logic write_enable_latch // Latch state
);
	logic [`SFWEC_SYNC_BITS-1:0] pins_s;
	logic sck_s;
	logic cs_b_s;
	logic mosi_s;
	logic sck_d;
	logic rise;
	logic fall;
	sfwec_pkg::sfwec_state_t state;
	sfwec_pkg::sfwec_state_t next_state;
	logic [2:0] bit_cnt;
	logic [2:0] next_bit_cnt;
	logic [7:0] rx;
	logic [7:0] next_rx;
	logic [7:0] rx_byte;
	logic [7:0] opcode;
	logic [7:0] next_opcode;
	logic [`SFWEC_ADDR_BITS-1:0] addr;
	logic [`SFWEC_ADDR_BITS-1:0] next_addr;
	logic wr_latch;
	logic next_wr_latch;
	logic [1:0] guard;
	logic [1:0] next_guard;
	logic wrote;
	logic next_wrote;
	logic [7:0] tx;
	logic [7:0] next_tx;
	logic next_miso;
	logic next_miso_oe_b;
	logic mem_we;
	logic [7:0] mem_rdata;
	logic [7:0] status_byte;
	logic [7:0] src_byte;
	logic op_is_write;
	logic op_is_read;
	logic byte_end;

	sfwec_sync u_sync (
		.clock(clock),
		.rst_b(rst_b),
		.async_in({spi_mosi, ~spi_cs_b, spi_clk}),
		.sync_out(pins_s)
	);

	sfwec_mem u_mem (
		.clock(clock),
		.rst_b(rst_b),
		.we(mem_we),
		.addr(addr),
		.wdata(rx_byte),
		.rdata(mem_rdata)
	);

	assign sck_s = pins_s[0];
	// Select is synchronised inverted, so a cleared stage reads as deselected after reset
	assign cs_b_s = ~pins_s[1];
	assign mosi_s = pins_s[2];
	assign rise = sck_s & ~sck_d;
	assign fall = ~sck_s & sck_d;
	assign rx_byte = {rx[6:0], mosi_s};
	assign byte_end = rise && (bit_cnt == `SFWEC_LAST_BIT) && !cs_b_s;
	assign op_is_write = (opcode == `SFWEC_OP_WRITE_LO) || (opcode == `SFWEC_OP_WRITE_HI);
	assign op_is_read = (opcode == `SFWEC_OP_READ_LO) || (opcode == `SFWEC_OP_READ_HI);

	// Unused bits are constant zero, so writes cannot reach them
	always_comb begin
		status_byte = 8'h00;
		status_byte[`SFWEC_SR_LATCH_BIT] = wr_latch;
		status_byte[`SFWEC_SR_GUARD_LOW_BIT] = guard[0];
		status_byte[`SFWEC_SR_GUARD_HIGH_BIT] = guard[1];
	end

	assign src_byte = (opcode == `SFWEC_OP_STATUS_READ) ? status_byte : mem_rdata;

	always_comb begin
		next_state = state;
		next_bit_cnt = bit_cnt;
		next_rx = rx;
		next_opcode = opcode;
		next_addr = addr;
		next_wr_latch = wr_latch;
		next_guard = guard;
		next_wrote = wrote;
		next_tx = tx;
		next_miso = spi_miso;
		next_miso_oe_b = spi_miso_oe_b;
		mem_we = 1'b0;
		if (cs_b_s) begin
			if (state != sfwec_pkg::SFWEC_IDLE) begin
				// Frame end; the upper-half write opcode is missing here on purpose
				if (wrote && ((opcode == `SFWEC_OP_WRITE_LO) || (opcode == `SFWEC_OP_STATUS_WRITE))) begin
					next_wr_latch = 1'b0;
				end
			end
			next_state = sfwec_pkg::SFWEC_IDLE;
			next_bit_cnt = 3'h0;
			next_miso_oe_b = 1'b1;
			next_wrote = 1'b0;
		end else if (state == sfwec_pkg::SFWEC_IDLE) begin
			next_state = sfwec_pkg::SFWEC_OPCODE;
			next_bit_cnt = 3'h0;
		end else begin
			if (rise) begin
				next_rx = rx_byte;
				next_bit_cnt = bit_cnt + 3'h1;
			end
			if (byte_end) begin
				case (state)
					sfwec_pkg::SFWEC_OPCODE: begin
						next_opcode = rx_byte;
						next_state = sfwec_pkg::SFWEC_DATA;
						case (rx_byte)
							`SFWEC_OP_SET_WRITE_LATCH: begin
								next_wr_latch = 1'b1;
							end
							`SFWEC_OP_CLEAR_WRITE_LATCH: begin
								next_wr_latch = 1'b0;
							end
							`SFWEC_OP_WRITE_LO, `SFWEC_OP_WRITE_HI, `SFWEC_OP_READ_LO, `SFWEC_OP_READ_HI: begin
								next_addr[`SFWEC_ADDR_BITS-1] = rx_byte[`SFWEC_OP_ADDR_MSB_BIT];
								next_state = sfwec_pkg::SFWEC_ADDR;
							end
							default: begin
								next_state = sfwec_pkg::SFWEC_DATA;
							end
						endcase
					end
					sfwec_pkg::SFWEC_ADDR: begin
						next_addr[7:0] = rx_byte;
						next_state = sfwec_pkg::SFWEC_DATA;
					end
					sfwec_pkg::SFWEC_DATA: begin
						if (op_is_write) begin
							mem_we = wr_latch;
							next_wrote = wrote | wr_latch;
							next_addr = addr + 9'h001;
						end else if (op_is_read) begin
							next_addr = addr + 9'h001;
						end else if ((opcode == `SFWEC_OP_STATUS_WRITE) && wr_latch) begin
							// Latch bit of the written byte is ignored; the latch clears at frame end
							next_guard = {rx_byte[`SFWEC_SR_GUARD_HIGH_BIT], rx_byte[`SFWEC_SR_GUARD_LOW_BIT]};
							next_wrote = 1'b1;
						end
					end
					default: begin
						next_state = sfwec_pkg::SFWEC_IDLE;
					end
				endcase
			end
			// Data leaves on the falling edge; read data was fetched several clocks earlier
			if (fall) begin
				if ((bit_cnt == 3'h0) && (state == sfwec_pkg::SFWEC_DATA)
					&& (op_is_read || (opcode == `SFWEC_OP_STATUS_READ))) begin
					next_miso = src_byte[7];
					next_tx = {src_byte[6:0], 1'b0};
					next_miso_oe_b = 1'b0;
				end else begin
					next_miso = tx[7];
					next_tx = {tx[6:0], 1'b0};
				end
			end
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			sck_d <= 1'b0;
			state <= sfwec_pkg::SFWEC_IDLE;
			bit_cnt <= 3'h0;
			rx <= 8'h00;
			opcode <= 8'h00;
			addr <= 9'h000;
			wr_latch <= `SFWEC_SR_LATCH_RESET;
			guard <= `SFWEC_SR_GUARD_RESET;
			wrote <= 1'b0;
			tx <= 8'h00;
			spi_miso <= 1'b0;
			spi_miso_oe_b <= 1'b1;
			write_enable_latch <= 1'b0;
		end else begin
			sck_d <= sck_s;
			state <= next_state;
			bit_cnt <= next_bit_cnt;
			rx <= next_rx;
			opcode <= next_opcode;
			addr <= next_addr;
			wr_latch <= next_wr_latch;
			guard <= next_guard;
			wrote <= next_wrote;
			tx <= next_tx;
			spi_miso <= next_miso;
			spi_miso_oe_b <= next_miso_oe_b;
			write_enable_latch <= next_wr_latch;
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_b);

	property p_set_latch;
		(byte_end && state == sfwec_pkg::SFWEC_OPCODE && rx_byte == `SFWEC_OP_SET_WRITE_LATCH)
			|=> wr_latch ##1 write_enable_latch;
	endproperty
	a_set_latch: assert property (p_set_latch) else $error("latch not set by set command");

	property p_status_write_keeps_latch;
		(byte_end && state == sfwec_pkg::SFWEC_DATA && opcode == `SFWEC_OP_STATUS_WRITE)
			|=> wr_latch == $past(wr_latch);
	endproperty
	a_status_write_keeps_latch: assert property (p_status_write_keeps_latch) else $error("status write moved latch");

	property p_low_write_clears;
		(cs_b_s && state != sfwec_pkg::SFWEC_IDLE && wrote && opcode == `SFWEC_OP_WRITE_LO)
			|=> !wr_latch ##1 !write_enable_latch;
	endproperty
	a_low_write_clears: assert property (p_low_write_clears) else $error("latch not cleared after write");

	property p_status_write_clears;
		(cs_b_s && state != sfwec_pkg::SFWEC_IDLE && wrote && opcode == `SFWEC_OP_STATUS_WRITE)
			|=> !wr_latch ##1 !write_enable_latch;
	endproperty
	a_status_write_clears: assert property (p_status_write_clears) else $error("status write left latch set");

	property p_high_write_keeps;
		(cs_b_s && state != sfwec_pkg::SFWEC_IDLE && opcode == `SFWEC_OP_WRITE_HI) |=> wr_latch == $past(wr_latch);
	endproperty
	a_high_write_keeps: assert property (p_high_write_keeps) else $error("upper write changed latch");

	property p_latch_rises_only_on_set;
		$rose(wr_latch) |-> $past(byte_end && state == sfwec_pkg::SFWEC_OPCODE && rx_byte == `SFWEC_OP_SET_WRITE_LATCH);
	endproperty
	a_latch_rises_only_on_set: assert property (p_latch_rises_only_on_set) else $error("latch rose without set");

	property p_write_needs_latch;
		mem_we |-> wr_latch && op_is_write;
	endproperty
	a_write_needs_latch: assert property (p_write_needs_latch) else $error("memory written with latch clear");

	property p_status_reserved_zero;
		(fall && !cs_b_s && bit_cnt == 3'h0 && state == sfwec_pkg::SFWEC_DATA && opcode == `SFWEC_OP_STATUS_READ)
			|=> !spi_miso && tx[7:5] == 3'h0 && tx[1] == 1'b0;
	endproperty
	a_status_reserved_zero: assert property (p_status_reserved_zero) else $error("reserved status bit not zero");

	property p_guard_write;
		(byte_end && state == sfwec_pkg::SFWEC_DATA && opcode == `SFWEC_OP_STATUS_WRITE && wr_latch)
			|=> guard == $past(rx_byte[3:2]);
	endproperty
	a_guard_write: assert property (p_guard_write) else $error("guard bits not stored");

	property p_clear_latch;
		(byte_end && state == sfwec_pkg::SFWEC_OPCODE && rx_byte == `SFWEC_OP_CLEAR_WRITE_LATCH) |=> !wr_latch;
	endproperty
	a_clear_latch: assert property (p_clear_latch) else $error("latch not cleared by clear command");

	property p_addr_msb_from_opcode;
		(byte_end && state == sfwec_pkg::SFWEC_OPCODE
			&& (rx_byte == `SFWEC_OP_WRITE_HI || rx_byte == `SFWEC_OP_READ_HI)) |=> addr[8] ##1 addr[8];
	endproperty
	a_addr_msb_from_opcode: assert property (p_addr_msb_from_opcode) else $error("address bit 8 not taken");

	property p_idle_released;
		cs_b_s |=> spi_miso_oe_b;
	endproperty
	a_idle_released: assert property (p_idle_released) else $error("data out driven while deselected");
endmodule

// ---- sfwec_host.sv ----
`timescale 1ns/100ps
module sfwec_host (
	output logic spi_clk, // Serial clock, still between frames
	output logic spi_cs_b, // Chip select, active low
	output logic spi_mosi, // Serial data to the device
	input wire logic spi_miso, // Serial data from the device
	input wire logic spi_miso_oe_b // Device drive enable, low active
);
	logic [7:0] rx_q[$];
	logic [7:0] r;
	initial begin
		spi_clk = 1'b0;
		spi_cs_b = 1'b1;
		spi_mosi = 1'b0;
		r = 8'h00;
	end
	// Mode 0 at 64 ns; undriven data line reads as the inverse of the last bit
	task automatic frame(input logic [7:0] tx[$]);
		rx_q.delete();
		spi_cs_b = 1'b0;
		#32;
		foreach (tx[k]) begin
			for (int i = 7; i >= 0; i--) begin
				spi_mosi = tx[k][i];
				#32 spi_clk = 1'b1;
				r = {r[6:0], spi_miso_oe_b ? ~r[0] : spi_miso};
				#32 spi_clk = 1'b0;
			end
			rx_q.push_back(r);
		end
		#32 spi_cs_b = 1'b1;
		spi_mosi = ~spi_mosi;
		#128;
	endtask
endmodule

// ---- sfwec_top_tb.sv ----
`timescale 1ns/100ps
module sfwec_top_tb;
	logic clock, rst_b, spi_clk, spi_cs_b, spi_mosi, spi_miso, spi_miso_oe_b, write_enable_latch;
	int n_mismatch, checks_done, latch_m, guard;
	int mem[int];
	logic [7:0] d, e;
	initial clock = 1'b0;
	always #2.5 clock = ~clock;
	sfwec_top DUT (.clock(clock), .rst_b(rst_b), .spi_clk(spi_clk), .spi_cs_b(spi_cs_b), .spi_mosi(spi_mosi),
		.spi_miso(spi_miso), .spi_miso_oe_b(spi_miso_oe_b), .write_enable_latch(write_enable_latch));
	sfwec_host host (.spi_clk(spi_clk), .spi_cs_b(spi_cs_b), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
		.spi_miso_oe_b(spi_miso_oe_b));
	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic summarize();
		$display("Checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// Reference model runs first, then the frame goes out and results are compared
	task automatic cmd(input logic [7:0] tx[$]);
		logic [7:0] op;
		int a;
		op = tx[0];
		a = (tx.size() > 1) ? {op[3], tx[1]} : 0;
		case (op)
			8'h06: latch_m = 1;
			8'h04: latch_m = 0;
			8'h01: if (latch_m == 1) begin
				guard = tx[1][3:2];
				latch_m = 0;
			end
			8'h02, 8'h0a: if (latch_m == 1) begin
				for (int i = 2; i < tx.size(); i++)
					mem[(a + i - 2) % 512] = tx[i];
				if (op == 8'h02)
					latch_m = 0;
			end
			default: ;
		endcase
		host.frame(tx);
		chk("write_enable_latch", {7'h00, write_enable_latch}, latch_m[7:0]);
		chk("spi_miso_oe_b", {7'h00, spi_miso_oe_b}, 8'h01);
		if (op == 8'h05)
			chk("status", host.rx_q[1], {4'h0, guard[1:0], latch_m[0], 1'h0});
		if (op == 8'h03 || op == 8'h0b) begin
			for (int i = 2; i < tx.size(); i++)
				chk("read_byte", host.rx_q[i], mem[(a + i - 2) % 512][7:0]);
		end
	endtask
	initial begin
		#400000;
		n_mismatch++;
		summarize();
	end
	initial begin
		void'($urandom(86780));
		n_mismatch = 0;
		checks_done = 0;
		latch_m = 0;
		guard = 0;
		d = 8'h00;
		e = 8'h00;
		rst_b = 1'b0;
		repeat (4) @(negedge clock);
		rst_b = 1'b1;
		repeat (4) @(negedge clock);
		cmd('{8'h05, 8'h00});
		cmd('{8'h06});
		d = $urandom;
		e = $urandom;
		cmd('{8'h02, 8'h5a, d, e});
		d = $urandom;
		cmd('{8'h02, 8'h5a, d});
		cmd('{8'h06});
		d = $urandom;
		cmd('{8'h0a, 8'h5a, d});
		d = $urandom;
		cmd('{8'h02, 8'h5b, d});
		cmd('{8'h03, 8'h5a, 8'h00, 8'h00});
		cmd('{8'h0b, 8'h5a, 8'h00});
		cmd('{8'h06});
		d = $urandom;
		e = $urandom;
		cmd('{8'h0a, 8'hff, d, e});
		cmd('{8'h04});
		d = $urandom;
		cmd('{8'h0a, 8'hff, d});
		cmd('{8'h0b, 8'hff, 8'h00, 8'h00});
		for (int k = 0; k < 4; k++) begin
			if (k % 2 == 0)
				cmd('{8'h06});
			d = $urandom;
			cmd('{8'h01, d});
			cmd('{8'h05, 8'h00});
		end
		cmd('{8'h06});
		d = $urandom;
		cmd('{8'h0a, 8'h10, d});
		cmd('{8'h01, 8'hff});
		cmd('{8'h05, 8'h00});
		// Mid-run reset with latch and guard bits set; the array keeps its contents
		cmd('{8'h06});
		@(negedge clock);
		rst_b = 1'b0;
		repeat (4) @(negedge clock);
		rst_b = 1'b1;
		latch_m = 0;
		guard = 0;
		repeat (4) @(negedge clock);
		chk("write_enable_latch", {7'h00, write_enable_latch}, 8'h00);
		cmd('{8'h05, 8'h00});
		cmd('{8'h0b, 8'h10, 8'h00});
		summarize();
	end
endmodule
